// ==== hw/pss_top.sv ====
// pedestrian and pedal cyclist signal sequencer, one crossing plus diagonal
`timescale 1ns/1ps
`include "pss_defines.svh"

// Contract
// - each crossing cycles steady green, then flashing red, then steady red.
// - green never lit together with flashing or steady red on one crossing.
// - steady green ends straight into flashing red, nothing between.
// - steady green lasts the configured time, never under four seconds.
// - clearance must finish before vehicular all-red of the intergreen ends.
// - flashing red at most clearance time; steady red fills the remainder.
// - flashing red not below lesser of 75% clearance and clearance minus intergreen.
// - no conflicting exclusive turn while the crossing shows green.
// - vehicular green starts with crossing green, optional delay capped at three seconds.
// - mid-block without flashing clearance holds vehicular red through green and flash.
// - flashing-clearance mode shows vehicular flashing red exactly during crossing flash.
// - serve crossing only on demand; otherwise signal a shorter vehicular green. Scramble starts the crossing without demand.
// - vehicular flashing mode blanks crossing aspects unless in flashing-clearance mode.
// - scramble holds all vehicular red and greens all crossings, diagonals optional.
// - protected turning phases keep conflicting crossings at steady red.
module pss_top
  import pss_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `PSS_SEC_CYCLES,
  parameter int unsigned FLASH_HALF_CYCLES = `PSS_FLASH_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] cfg_green_s,
  input wire logic [7:0] cfg_clear_s,
  input wire logic [7:0] cfg_intergreen_s,
  input wire logic [7:0] cfg_veh_delay_s,
  input wire logic mode_midblock,
  input wire logic mode_flash_clear,
  input wire logic mode_scramble,
  input wire logic diag_enable,
  input wire logic veh_flashing,
  input wire logic turn_protected,
  input wire logic phase_start,
  input wire logic button,
  output logic lamp_green,
  output logic lamp_red,
  output logic lamp_diag_green,
  output logic lamp_diag_red,
  output logic veh_hold_red,
  output logic veh_flash_red,
  output logic veh_green_permit,
  output logic turn_inhibit,
  output logic hold_allred,
  output logic short_green,
  output logic demand_pending,
  output pss_pkg::pss_state_t seq_state
);

  import pss_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  // shortest permitted flash keeps the most steady red after it
  function automatic logic [7:0] flash_len(input logic [7:0] c, input logic [7:0] ig);
    logic [9:0] pct;
    logic [7:0] pct_s;
    logic [7:0] diff;
    pct = ({2'b00, c} * `PSS_FLASH_PCT_MUL + `PSS_FLASH_PCT_MUL) >> `PSS_FLASH_PCT_SHIFT;
    pct_s = pct[7:0];
    diff = (c > ig) ? (c - ig) : `PSS_SEC_ZERO;
    flash_len = min8(c, max8(min8(pct_s, diff), `PSS_MIN_FLASH_S));
  endfunction

  // ************************************************************
  // enables and demand
  // ************************************************************
  pss_state_t state_q;
  pss_state_t state_d;
  logic [7:0] sec_q;
  logic [7:0] sec_d;
  logic flash_on_q;
  logic flash_on_d;
  logic sec_tick;
  logic flash_tick;
  logic state_change;
  logic flash_entry;
  logic green_start;
  logic pending;
  logic blank;
  logic pelican;

  assign state_change = (state_d != state_q);
  assign flash_entry = state_change && (state_d == PSS_FLASH);
  assign green_start = state_change && (state_d == PSS_GREEN);
  assign pelican = mode_midblock && mode_flash_clear;
  assign blank = veh_flashing && !pelican;

  pss_divider #(
    .DIV(SEC_CYCLES)
  ) u_sec (
    .clk(clk),
    .reset_n(reset_n),
    .restart(state_change),
    .tick(sec_tick)
  );

  pss_divider #(
    .DIV(FLASH_HALF_CYCLES)
  ) u_flash (
    .clk(clk),
    .reset_n(reset_n),
    .restart(flash_entry),
    .tick(flash_tick)
  );

  pss_demand u_demand (
    .clk(clk),
    .reset_n(reset_n),
    .press(button),
    .green_start(green_start),
    .pending(pending)
  );

  // ************************************************************
  // sequence
  // ************************************************************
  logic [7:0] green_len;
  logic [7:0] flash_s;
  logic [7:0] red_s;
  logic [7:0] delay_s;
  logic last_sec;

  assign green_len = max8(cfg_green_s, `PSS_MIN_GREEN_S);
  assign flash_s = flash_len(cfg_clear_s, cfg_intergreen_s);
  assign red_s = cfg_clear_s - flash_s;
  assign delay_s = min8(cfg_veh_delay_s, `PSS_VEH_DELAY_MAX_S);

  always_comb begin
    state_d = state_q;
    sec_d = sec_q;
    last_sec = 1'b0;
    if (sec_tick) begin
      sec_d = sec_q + `PSS_SEC_ONE;
    end
    unique case (state_q)
      PSS_IDLE: begin
        // demand or scramble, never during a protected turn
        if (phase_start && (pending || mode_scramble) && !turn_protected && !blank) begin
          state_d = PSS_GREEN;
        end
      end
      PSS_GREEN: begin
        last_sec = sec_tick && (sec_d == green_len);
        if (last_sec) begin
          state_d = PSS_FLASH;
        end
      end
      PSS_FLASH: begin
        last_sec = sec_tick && (sec_d == flash_s);
        if (last_sec) begin
          state_d = (red_s == `PSS_SEC_ZERO) ? PSS_IDLE : PSS_RED_CLR;
        end
      end
      PSS_RED_CLR: begin
        last_sec = sec_tick && (sec_d == red_s);
        if (last_sec) begin
          state_d = PSS_IDLE;
        end
      end
    endcase
    if (blank) begin
      state_d = PSS_IDLE;
    end
    if (state_d != state_q) begin
      sec_d = `PSS_SEC_ZERO;
    end
  end

  always_comb begin
    flash_on_d = flash_on_q;
    if (flash_entry) begin
      flash_on_d = 1'b1;
    end else if (flash_tick) begin
      flash_on_d = !flash_on_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PSS_IDLE;
      sec_q <= `PSS_SEC_ZERO;
      flash_on_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sec_q <= sec_d;
      flash_on_q <= flash_on_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // all outputs are registered, the sequence outputs from the next state, so lamps follow the sequence
  // without a cycle of glitch when the state changes
  logic lamp_green_d;
  logic lamp_red_d;
  logic lamp_diag_green_d;
  logic lamp_diag_red_d;
  logic veh_hold_red_d;
  logic veh_flash_red_d;
  logic veh_green_permit_d;
  logic turn_inhibit_d;
  logic hold_allred_d;
  logic short_green_d;
  logic busy_d;
  logic flash_lit_d;
  logic [7:0] sec_next_green;

  assign sec_next_green = (state_d == PSS_GREEN) ? sec_d : `PSS_SEC_ZERO;

  always_comb begin
    busy_d = (state_d != PSS_IDLE);
    flash_lit_d = flash_on_d || flash_entry;
    lamp_green_d = (state_d == PSS_GREEN);
    lamp_red_d = (state_d == PSS_IDLE) || (state_d == PSS_RED_CLR) ||
                 ((state_d == PSS_FLASH) && flash_lit_d);
    if (blank) begin
      lamp_green_d = 1'b0;
      lamp_red_d = 1'b0;
    end
    lamp_diag_green_d = lamp_green_d && mode_scramble && diag_enable;
    lamp_diag_red_d = diag_enable && !blank && !lamp_diag_green_d && lamp_red_d;
    // scramble holds every approach; mid-block holds through green and flash, only through green with flashing clearance
    veh_hold_red_d = (mode_scramble && busy_d) ||
                     (mode_midblock && !mode_flash_clear &&
                      ((state_d == PSS_GREEN) || (state_d == PSS_FLASH)));
    if (mode_midblock && mode_flash_clear && (state_d == PSS_GREEN)) begin
      veh_hold_red_d = 1'b1;
    end
    veh_flash_red_d = pelican && (state_d == PSS_FLASH);
    // a long delay invites wrong-way crossing, so it is capped
    veh_green_permit_d = busy_d && !mode_midblock && !mode_scramble &&
                         !((state_d == PSS_GREEN) && (sec_next_green < delay_s));
    turn_inhibit_d = (state_d == PSS_GREEN);
    hold_allred_d = busy_d && !mode_midblock;
    short_green_d = !pending && !busy_d;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_green <= 1'b0;
      lamp_red <= 1'b1;
      lamp_diag_green <= 1'b0;
      lamp_diag_red <= 1'b0;
      veh_hold_red <= 1'b0;
      veh_flash_red <= 1'b0;
      veh_green_permit <= 1'b0;
      turn_inhibit <= 1'b0;
      hold_allred <= 1'b0;
      short_green <= 1'b1;
      demand_pending <= 1'b0;
      seq_state <= PSS_IDLE;
    end else begin
      lamp_green <= lamp_green_d;
      lamp_red <= lamp_red_d;
      lamp_diag_green <= lamp_diag_green_d;
      lamp_diag_red <= lamp_diag_red_d;
      veh_hold_red <= veh_hold_red_d;
      veh_flash_red <= veh_flash_red_d;
      veh_green_permit <= veh_green_permit_d;
      turn_inhibit <= turn_inhibit_d;
      hold_allred <= hold_allred_d;
      short_green <= short_green_d;
      demand_pending <= pending;
      seq_state <= state_d;
    end
  end

endmodule

// ==== hw/pss_defines.svh ====
// timing and limit constants for the pedestrian signal sequencer
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define PSS_CLK_HZ 40000000
`define PSS_SEC_S 1
`define PSS_SEC_CYCLES (`PSS_CLK_HZ * `PSS_SEC_S)
`define PSS_FLASH_HALF_MS 500
`define PSS_FLASH_HALF_CYCLES ((`PSS_CLK_HZ / 1000) * `PSS_FLASH_HALF_MS)

// ************************************************************
// interval limits, in seconds, and the flash percentage scale
// ************************************************************
`define PSS_MIN_GREEN_S 8'h04
`define PSS_VEH_DELAY_MAX_S 8'h03
`define PSS_MIN_FLASH_S 8'h01
`define PSS_FLASH_PCT_MUL 10'h003
`define PSS_FLASH_PCT_SHIFT 2
`define PSS_SEC_ZERO 8'h00
`define PSS_SEC_ONE 8'h01

`endif

// ==== hw/pss_pkg.sv ====
// types shared by the pedestrian signal sequencer
package pss_pkg;

  typedef enum logic [1:0] {
    PSS_IDLE,
    PSS_GREEN,
    PSS_FLASH,
    PSS_RED_CLR
  } pss_state_t;

endpackage

// ==== hw/pss_divider.sv ====
// restartable divider producing a one-cycle enable pulse
`timescale 1ns/1ps

module pss_divider #(
  parameter int unsigned DIV = 40000000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  output logic tick
);

  localparam int unsigned CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // ************************************************************
  // count
  // ************************************************************
  // restart loads one: the entry cycle counts, so a timed state lasts whole periods exactly
  always_comb begin
    cnt_d = cnt_q + CW'(1);
    tick_d = 1'b0;
    if (restart) begin
      cnt_d = CW'(1);
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// ==== hw/pss_demand.sv ====
// push-button demand latch
`timescale 1ns/1ps

module pss_demand (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic press,
  input wire logic green_start,
  output logic pending
);

  logic pend_q;
  logic pend_d;

  // ************************************************************
  // latch
  // ************************************************************
  // a press in the clearing cycle stays latched for the next cycle
  always_comb begin
    pend_d = pend_q;
    if (green_start) begin
      pend_d = 1'b0;
    end
    if (press) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

endmodule

// ==== bench/pss_far_side.sv ====
// far-side model: push button and vehicular phase controller
`timescale 1ns/1ps
module pss_far_side (
  input wire logic clk,
  input wire logic press,
  input wire logic want,
  output logic button,
  output logic phase_start
);
  // ************
  // button and phase request
  // ************
  logic [1:0] hold_q;
  initial begin
    hold_q = 2'h0;
    button = 1'b0;
    phase_start = 1'b0;
  end
  // a press is held a few cycles, as a hand on a button would be
  always @(negedge clk) begin
    hold_q <= press ? 2'h3 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
    button <= press || hold_q != 2'h0;
    phase_start <= want;
  end
endmodule

// ==== bench/pss_top_props.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module pss_top_chk #(
  parameter int unsigned SEC_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mode_midblock,
  input wire logic mode_flash_clear,
  input wire logic veh_flashing,
  input wire logic lamp_green,
  input wire logic lamp_red,
  input wire logic veh_hold_red,
  input wire logic veh_flash_red,
  input wire logic turn_inhibit,
  input wire pss_pkg::pss_state_t seq_state
);
  import pss_pkg::*;
  // ************
  // green length counter
  // ************
  logic [15:0] grn_q;
  logic [15:0] grn_d;
  always_comb begin
    grn_d = lamp_green ? grn_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grn_q <= 16'h0000;
    end else begin
      grn_q <= grn_d;
    end
  end
  // ************
  // properties
  // ************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  lamp_mutex_a: assert property (!(lamp_green && lamp_red))
    else $error("green and red lit together");
  flash_order_a: assert property ($changed(seq_state) && seq_state == PSS_FLASH
    |-> $past(seq_state) == PSS_GREEN) else $error("flash not entered from green");
  green_to_flash_a: assert property ($fell(lamp_green) && !$past(veh_flashing)
    |-> seq_state == PSS_FLASH && lamp_red) else $error("green not followed by lit flash");
  min_green_a: assert property ($fell(lamp_green) && seq_state == PSS_FLASH
    |-> grn_q >= 16'(4 * SEC_CYCLES)) else $error("green shorter than minimum");
  turn_block_a: assert property (lamp_green |-> turn_inhibit)
    else $error("turn not inhibited during green");
  mid_veh_red_a: assert property (mode_midblock && !mode_flash_clear
    && (lamp_green || seq_state == PSS_FLASH) |-> veh_hold_red) else $error("vehicle red missing");
  pelican_flash_a: assert property (mode_midblock && mode_flash_clear
    |-> veh_flash_red == (seq_state == PSS_FLASH)) else $error("vehicle flash mismatch");
  blank_lamps_a: assert property (veh_flashing && !(mode_midblock && mode_flash_clear)
    |=> !lamp_green && !lamp_red) else $error("lamps not blanked");
  red_clear_c: cover property (seq_state == PSS_RED_CLR);
  pelican_c: cover property (veh_flash_red);
  blank_c: cover property (veh_flashing && lamp_green);
endmodule

bind pss_top pss_top_chk #(.SEC_CYCLES(SEC_CYCLES)) chk_i (.clk(clk), .reset_n(reset_n),
  .mode_midblock(mode_midblock), .mode_flash_clear(mode_flash_clear),
  .veh_flashing(veh_flashing), .lamp_green(lamp_green), .lamp_red(lamp_red),
  .veh_hold_red(veh_hold_red), .veh_flash_red(veh_flash_red),
  .turn_inhibit(turn_inhibit), .seq_state(seq_state));

// ==== bench/tb_pss_top.sv ====
// self-checking bench for the pedestrian signal sequencer
`timescale 1ns/1ps
module tb_pss_top;
  import pss_pkg::*;
  // ************
  // signals and instances
  // ************
  logic clk, reset_n, press, want, button, phase_start, saw_diag;
  logic mid, pel, scr, diag, vf, tp, lg, lr, ldg, ldr, vhr, vfr, vgp, ti, har, sg, dp;
  logic [7:0] grn, clr, itg, dly;
  logic [15:0] g, f, r, v, h;
  pss_state_t st;
  int errors, compares, cyc;
  pss_top #(.SEC_CYCLES(20), .FLASH_HALF_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
    .cfg_green_s(grn), .cfg_clear_s(clr), .cfg_intergreen_s(itg), .cfg_veh_delay_s(dly),
    .mode_midblock(mid), .mode_flash_clear(pel), .mode_scramble(scr), .diag_enable(diag),
    .veh_flashing(vf), .turn_protected(tp), .phase_start(phase_start), .button(button),
    .lamp_green(lg), .lamp_red(lr), .lamp_diag_green(ldg), .lamp_diag_red(ldr),
    .veh_hold_red(vhr), .veh_flash_red(vfr), .veh_green_permit(vgp), .turn_inhibit(ti),
    .hold_allred(har), .short_green(sg), .demand_pending(dp), .seq_state(st));
  pss_far_side far (.clk(clk), .press(press), .want(want), .button(button),
    .phase_start(phase_start));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ************
  // tasks
  // ************
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic tap();
    press <= 1'b1;
    @(negedge clk);
    press <= 1'b0;
  endtask
  // counts cycles spent in each state of one full crossing sequence
  task automatic run_seq();
    int n;
    n = 0;
    {g, f, r, v, h} = 80'h0;
    want <= 1'b1;
    while (st === PSS_IDLE && n < 50) begin
      @(negedge clk);
      n++;
    end
    want <= 1'b0;
    while (st !== PSS_IDLE && n < 600) begin
      if (st === PSS_GREEN) g++;
      else if (st === PSS_FLASH) f++;
      else r++;
      if (vgp === 1'b1) v++;
      if (har === 1'b1) h++;
      if (ldg === 1'b1) saw_diag = 1'b1;
      @(negedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  // ************
  // main sequence
  // ************
  initial begin
    reset_n = 1'b0;
    {press, want, mid, pel, scr, diag, vf, tp, saw_diag} = 9'h000;
    grn = 8'h02; // below the floor on purpose, so the clamp shows
    clr = 8'h04;
    itg = 8'h02;
    dly = 8'h01;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_n <= 1'b1;
    tap();
    repeat (3) @(negedge clk);
    chk("demand_pending", 16'h0001, 16'(dp));
    tp <= 1'b1;
    want <= 1'b1;
    repeat (6) @(negedge clk);
    chk("turn_refused", 16'h0000, 16'(st));
    tp <= 1'b0;
    run_seq();
    chk("green_cycles", 16'h0050, g);
    chk("flash_cycles", 16'h0028, f);
    chk("red_cycles", 16'h0028, r);
    chk("demand_cleared", 16'h0000, 16'(dp));
    chk("veh_permit_cycles", 16'h008C, v);
    chk("allred_hold_cycles", 16'h00A0, h);
    want <= 1'b1;
    repeat (6) @(negedge clk);
    chk("no_demand_idle", 16'h0000, 16'(st));
    chk("short_green", 16'h0001, 16'(sg));
    scr <= 1'b1;
    diag <= 1'b1;
    run_seq();
    chk("diag_green", 16'h0001, 16'(saw_diag));
    chk("scramble_green", 16'h0050, g);
    chk("scramble_permit", 16'h0000, v);
    chk("diag_red", 16'h0001, 16'(ldr));
    {scr, diag} <= 2'h0;
    mid <= 1'b1;
    pel <= 1'b1;
    clr <= 8'h08;
    itg <= 8'h01;
    tap();
    run_seq();
    chk("pelican_flash", 16'h0078, f);
    chk("pelican_red", 16'h0028, r);
    chk("pelican_permit", 16'h0000, v);
    pel <= 1'b0;
    tap();
    want <= 1'b1;
    for (int i = 0; i < 50 && st !== PSS_GREEN; i++) @(negedge clk);
    want <= 1'b0;
    repeat (5) @(negedge clk);
    vf <= 1'b1;
    repeat (2) @(negedge clk);
    chk("blank_lamps", 16'h0000, 16'({lg, lr}));
    chk("blank_state", 16'h0000, 16'(st));
    vf <= 1'b0;
    report_and_stop();
  end
endmodule
